// [addr_assign_pkg.sv]
package addr_assign_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ          = 100;
  localparam int T_UV_MAX_NS      = 5000;
  localparam int T_RCV_NS         = 100000;
  localparam int T_D_CAPTEST_NS   = 4000;
  localparam int T_P_CAPTEST_NS   = 9200;
  localparam int T_A_CAPTEST_NS   = 179200;
  localparam int T_CAPTEST_NS     = 1000;
  localparam int UV_CYC           = T_UV_MAX_NS * CLK_MHZ / 1000;
  localparam int RCV_CYC          = (T_RCV_NS * CLK_MHZ + 999) / 1000;
  localparam int D_CAPTEST_CYC    = T_D_CAPTEST_NS * CLK_MHZ / 1000;
  localparam int P_CAPTEST_CYC    = T_P_CAPTEST_NS * CLK_MHZ / 1000;
  localparam int A_CAPTEST_CYC    = T_A_CAPTEST_NS * CLK_MHZ / 1000;
  localparam int CAPTEST_CYC      = T_CAPTEST_NS * CLK_MHZ / 1000;
  localparam int START_FILT_CYC   = 4;

  // ****************************************
  // commands
  // ****************************************
  localparam logic [3:0] GLOBAL_ADDR = 4'h0;
  localparam logic [3:0] CMD_WR_ADDR = 4'h1;
  localparam logic [3:0] RESET_ADDR  = 4'h0;

  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] cmd;
    logic [7:0] data;
  } command_t;

  typedef struct packed {
    logic single_current;
    logic double_current;
  } resp_drive_t;

endpackage : addr_assign_pkg

// [cmd_start_counter.sv]
// ****************************************
// comparator low-time counter
// ****************************************
module cmd_start_counter
  import addr_assign_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // synchronised comparator level
  input  wire logic             comp_level,
  // derived signals
  output logic [WIDTH-1:0]      low_count,
  output logic                  cmd_start
);
  logic             next_start;

  // count cycles the comparator stays low; saturate
  always_ff @(posedge clock) begin
    if (sys_rst || comp_level) begin
      low_count <= '0;
    end else if (low_count != {WIDTH{1'b1}}) begin
      low_count <= low_count + 1'b1;
    end
  end

  // start is a pulse once the low time passes filter, rejecting glitches
  assign next_start = !comp_level && (low_count == WIDTH'(START_FILT_CYC));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_start <= 1'b0;
    end else begin
      cmd_start <= next_start;
    end
  end

  // a start pulse needs the comparator low at the two edges before it
  property p_start_after_low;
    @(posedge clock) disable iff (sys_rst)
    cmd_start |-> !$past(comp_level, 1) && !$past(comp_level, 2);
  endproperty
  a_start_after_low : assert property (p_start_after_low)
    else $error("start without low comparator");
endmodule // cmd_start_counter

// [addr_assign.sv]
// ****************************************
// slave address assignment and bus phy control
// ****************************************
module addr_assign
  import addr_assign_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // analog pins (asynchronous)
  input  wire logic        comp_out,
  input  wire logic        sense_high,
  input  wire logic        bus_uv,
  input  wire logic        buffer_supply_uv,
  input  wire logic        overvoltage,
  // otp and mode
  input  wire logic [3:0]  otp_location_register,
  input  wire logic        init_finished_flag,
  input  wire logic        psi5_mode,
  input  wire logic        psi5_async,
  // decoded commands from link layer
  input  wire logic        cmd_valid,
  input  wire command_t    cmd,
  input  wire logic        disc_cmd,
  input  wire logic        disc_window_end,
  input  wire logic        switch_on_req,
  // response request from link layer
  input  wire resp_drive_t resp_req,
  // outputs
  output resp_drive_t      resp_drive,
  output logic [3:0]       phys_addr,
  output logic             addr_valid,
  output logic             bus_switch_on,
  output logic             cmd_accept,
  output logic             cap_disconnect,
  output logic             cmd_start,
  output logic             discovery_active
);
  typedef enum logic [1:0] {DISC_IDLE, DISC_WAIT, DISC_DONE} disc_state_t;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1 <= 5'h1;
      sync2 <= 5'h1;
    end else begin
      sync1 <= {overvoltage, buffer_supply_uv, bus_uv, sense_high, comp_out};
      sync2 <= sync1;
    end
  end
  wire comp_s  = sync2[0];
  wire sense_s = sync2[1];
  wire fault_s = sync2[2] | sync2[3] | sync2[4];
  wire uv_s    = sync2[2] | sync2[3];

  // ****************************************
  // command start
  // ****************************************
  cmd_start_counter #(.WIDTH(8)) u_start (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .comp_level (comp_s),
    .low_count  (),
    .cmd_start  (cmd_start)
  );

  // ****************************************
  // fault recovery
  // ****************************************
  logic [16:0] rcv_cnt;
  wire         recovering = (rcv_cnt != 17'h0);
  // hold off after the fault clears; restart while fault persists
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rcv_cnt <= 17'h0;
    end else if (fault_s) begin
      rcv_cnt <= 17'(RCV_CYC);
    end else if (recovering) begin
      rcv_cnt <= rcv_cnt - 17'h1;
    end
  end
  wire halted = fault_s | recovering;

  // ****************************************
  // address assignment
  // ****************************************
  disc_state_t state;
  disc_state_t next_state;
  logic [3:0]  disc_cnt;
  wire         otp_set   = (otp_location_register != 4'h0);
  wire         own_hit   = addr_valid && (cmd.addr == phys_addr);
  wire         glob_wr   = !addr_valid && (cmd.addr == GLOBAL_ADDR) && (cmd.cmd == CMD_WR_ADDR)
                           && (cmd.data[3:0] != 4'h0);
  wire         sense_win = (state == DISC_WAIT) && disc_window_end;

  assign cmd_accept       = cmd_valid && !halted && (own_hit || glob_wr);
  assign discovery_active = (state == DISC_WAIT);

  // discovery runs only without an otp address or init flag
  always_comb begin
    next_state = state;
    unique case (state)
      DISC_IDLE: if (!otp_set && !init_finished_flag && !addr_valid && disc_cmd)
                   next_state = DISC_WAIT;
      DISC_WAIT: if (disc_window_end) next_state = !sense_s ? DISC_DONE : DISC_IDLE;
      DISC_DONE: next_state = DISC_DONE;
      default:   next_state = DISC_IDLE; // unused code falls back to watching
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state      <= DISC_IDLE;
      disc_cnt   <= 4'h0;
      phys_addr  <= RESET_ADDR;
      addr_valid <= 1'b0;
    end else begin
      state <= next_state;
      if (disc_cmd && state == DISC_IDLE && !addr_valid && !otp_set) begin
        disc_cnt <= disc_cnt + 4'h1;
      end
      if (otp_set && !addr_valid) begin
        phys_addr  <= otp_location_register;
        addr_valid <= 1'b1;
      end else if (sense_win && !sense_s && !addr_valid) begin
        phys_addr  <= disc_cnt;
        addr_valid <= 1'b1;
      end else if (cmd_valid && !halted && glob_wr) begin
        phys_addr  <= cmd.data[3:0];
        addr_valid <= 1'b1;
      end
    end
  end

  // ****************************************
  // bus switch; closed only by master traffic
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_switch_on <= 1'b0;
    end else if (switch_on_req && addr_valid && !halted) begin
      bus_switch_on <= 1'b1;
    end
  end

  // ****************************************
  // response drive; no power-class current modes exist
  // ****************************************
  resp_drive_t next_drive;
  assign next_drive = (halted || uv_s) ? '0 : resp_req;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      resp_drive <= '0;
    end else begin
      resp_drive <= next_drive;
    end
  end

  // ****************************************
  // buffer capacitor test
  // ****************************************
  logic [14:0] cap_cnt;
  logic        cap_arm;
  wire  [14:0] cap_delay = !psi5_mode ? 15'(D_CAPTEST_CYC)
                         : psi5_async ? 15'(A_CAPTEST_CYC) : 15'(P_CAPTEST_CYC);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cap_cnt        <= 15'h0;
      cap_arm        <= 1'b0;
      cap_disconnect <= 1'b0;
    end else if (cmd_start && !cap_arm) begin
      cap_cnt <= 15'h0;
      cap_arm <= 1'b1;
    end else if (cap_arm) begin
      cap_cnt <= cap_cnt + 15'h1;
      if (cap_cnt == cap_delay - 15'h1) begin
        cap_disconnect <= 1'b1;
      end
      if (cap_cnt == cap_delay + 15'(CAPTEST_CYC) - 15'h1) begin
        cap_disconnect <= 1'b0;
        cap_arm        <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_uv_off;
    @(posedge clock) disable iff (sys_rst)
    (bus_uv || buffer_supply_uv) |-> ##[1:4] (resp_drive == '0);
  endproperty
  a_uv_off : assert property (p_uv_off)
    else $error("response not cut on undervoltage");
  property p_switch_reset;
    @(posedge clock) disable iff (sys_rst)
    $rose(bus_switch_on) |-> $past(switch_on_req) && $past(addr_valid);
  endproperty
  a_switch_reset : assert property (p_switch_reset)
    else $error("switch closed without command");
  property p_accept_addr;
    @(posedge clock) disable iff (sys_rst)
    cmd_accept |-> (cmd.addr == phys_addr) || (cmd.addr == GLOBAL_ADDR);
  endproperty
  a_accept_addr : assert property (p_accept_addr)
    else $error("accepted foreign address");
  property p_otp_wins;
    @(posedge clock) disable iff (sys_rst)
    otp_set |=> ##1 (phys_addr == $past(otp_location_register, 2));
  endproperty
  a_otp_wins : assert property (p_otp_wins)
    else $error("otp address not taken");
  property p_no_disc_otp;
    @(posedge clock) disable iff (sys_rst)
    otp_set |-> ##1 !discovery_active || $past(discovery_active);
  endproperty
  a_no_disc_otp : assert property (p_no_disc_otp)
    else $error("discovery entered with otp address");
  property p_drive_follows;
    @(posedge clock) disable iff (sys_rst)
    (!halted && !uv_s) |=> (resp_drive == $past(resp_req));
  endproperty
  a_drive_follows : assert property (p_drive_follows)
    else $error("response drive mismatch");
  property p_rcv_hold;
    @(posedge clock) disable iff (sys_rst)
    $fell(fault_s) |-> (resp_drive == '0) [*8];
  endproperty
  a_rcv_hold : assert property (p_rcv_hold)
    else $error("resumed before recovery");
  // 392 is the dsi offset of 400 less the eight-cycle mode window
  property p_cap_start;
    @(posedge clock) disable iff (sys_rst)
    (cmd_start && !cap_arm && !psi5_mode) ##1 !psi5_mode [*8]
      |-> ##[392:392] !cap_disconnect ##1 cap_disconnect;
  endproperty
  a_cap_start : assert property (p_cap_start)
    else $error("cap test not started on time");
  property p_latch;
    @(posedge clock) disable iff (sys_rst)
    (sense_win && !sense_s && !addr_valid && !otp_set) |=> (phys_addr == $past(disc_cnt));
  endproperty
  a_latch : assert property (p_latch)
    else $error("discovery address not latched");
endmodule // addr_assign

// [dsi3_master_model.sv]
// ****************************************
// bus master model, decoded command side
// ****************************************
module dsi3_master_model
  import addr_assign_pkg::*;
(
  // clock
  input  wire logic clock,
  // command side toward the slave
  output logic      comp_out,
  output logic      cmd_valid,
  output command_t  cmd,
  output logic      disc_cmd,
  output logic      disc_window_end,
  output logic      switch_on_req,
  // slave answer
  input  wire logic cmd_accept
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus: comparator high, no strobes
  initial begin
    comp_out = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    {disc_cmd, disc_window_end, switch_on_req} = 3'h0;
  end

  // comparator level, low marks command activity
  task automatic pin(input logic lvl);
    @(posedge clock);
    comp_out <= lvl;
  endtask

  // one command, answer taken at the edge that takes the command
  task automatic send(input command_t c, output logic acc);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clock);
    acc = cmd_accept;
    cmd_valid <= 1'b0;
    cmd <= ~c; // scrambled idle word, so a stale value never looks valid
  endtask

  // one-cycle strobe: discovery, window end, switch close
  task automatic pulse(input logic [2:0] sel);
    @(posedge clock);
    {disc_cmd, disc_window_end, switch_on_req} <= sel;
    @(posedge clock);
    {disc_cmd, disc_window_end, switch_on_req} <= 3'h0;
  endtask
endmodule // dsi3_master_model

// [dsi3_slave_phy_address_assign_bench.sv]
module dsi3_slave_phy_address_assign_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import addr_assign_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, sense_high = 1'b0;
  logic bus_uv = 1'b0, buffer_supply_uv = 1'b0, overvoltage = 1'b0;
  logic init_finished_flag = 1'b0, psi5_mode = 1'b0, psi5_async = 1'b0;
  logic [3:0] otp = 4'h0, phys_addr;
  logic comp_out, cmd_valid, disc_cmd, disc_window_end, switch_on_req;
  logic addr_valid, bus_switch_on, cmd_accept, cap_disconnect, cmd_start, discovery_active;
  logic acc;
  command_t cmd;
  resp_drive_t resp_req = '0, resp_drive;
  int error_cnt = 0, check_count = 0, cyc = 0, n;
  logic [3:0] a;

  always #5 clock = ~clock;

  dsi3_master_model i_m (.clock(clock), .comp_out(comp_out), .cmd_valid(cmd_valid),
    .cmd(cmd), .disc_cmd(disc_cmd), .disc_window_end(disc_window_end),
    .switch_on_req(switch_on_req), .cmd_accept(cmd_accept));

  addr_assign i_dut (.clock(clock), .sys_rst(sys_rst), .comp_out(comp_out),
    .sense_high(sense_high), .bus_uv(bus_uv), .buffer_supply_uv(buffer_supply_uv),
    .overvoltage(overvoltage), .otp_location_register(otp),
    .init_finished_flag(init_finished_flag), .psi5_mode(psi5_mode),
    .psi5_async(psi5_async), .cmd_valid(cmd_valid), .cmd(cmd), .disc_cmd(disc_cmd),
    .disc_window_end(disc_window_end), .switch_on_req(switch_on_req),
    .resp_req(resp_req), .resp_drive(resp_drive), .phys_addr(phys_addr),
    .addr_valid(addr_valid), .bus_switch_on(bus_switch_on), .cmd_accept(cmd_accept),
    .cap_disconnect(cap_disconnect), .cmd_start(cmd_start),
    .discovery_active(discovery_active));

  // ****************************************
  // helpers
  // ****************************************
  // cap test offset for the mode index: dsi, psi5 sync, psi5 async
  function automatic int cap_delay(input int m);
    return (m == 0) ? D_CAPTEST_CYC : (m == 1) ? P_CAPTEST_CYC : A_CAPTEST_CYC;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // reset for two edges, then drive, address, valid, switch and cap outputs must be low; call at a rising edge
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("outs", 0, {resp_drive, phys_addr, addr_valid, bus_switch_on, cap_disconnect});
  endtask

  // hang guard, whole run needs about 30k cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      results();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(32'h58464ebd));
    // command start and cap test offset in all three modes
    for (int m = 0; m < 3; m++) begin
      @(posedge clock);
      psi5_mode <= (m > 0);
      psi5_async <= (m == 2);
      rst();
      i_m.pin(1'b0);
      n = 0;
      do begin @(negedge clock); n++; end while (cmd_start !== 1'b1 && n < 20);
      // two sync flops, filter count, output flop, then the half-cycle look
      chk("start", 2 + START_FILT_CYC + 2, n);
      i_m.pin(1'b1);
      n = 0;
      do begin @(negedge clock); n++; end while (cap_disconnect !== 1'b1 && n < 20000);
      // the first look falls half a cycle after the start edge
      chk("cap_at", cap_delay(m) + 1, n);
      n = 0;
      while (cap_disconnect === 1'b1 && n < 500) begin @(negedge clock); n++; end
      chk("cap_len", CAPTEST_CYC, n);
      $display("test cap mode %0d done", m);
    end
    // discovery: one pass with downstream current, then latch
    @(posedge clock);
    psi5_mode <= 1'b0;
    psi5_async <= 1'b0;
    sense_high <= 1'b1;
    rst();
    i_m.pulse(3'h4);
    @(negedge clock);
    chk("disc_on", 1, discovery_active);
    i_m.pulse(3'h2);
    repeat (3) @(negedge clock);
    chk("disc_wait", 2'b00, {discovery_active, addr_valid});
    i_m.pulse(3'h4);
    sense_high <= 1'b0;
    repeat (3) @(posedge clock);
    i_m.pulse(3'h2);
    repeat (2) @(negedge clock);
    chk("disc_addr", 5'h12, {addr_valid, phys_addr});
    i_m.send('{4'h2, 4'($urandom), 8'($urandom)}, acc);
    chk("own", 1, acc);
    i_m.send('{4'h3, 4'($urandom), 8'($urandom)}, acc);
    chk("other", 0, acc);
    $display("test discovery done");
    // init flag set: discovery commands are ignored
    @(posedge clock);
    init_finished_flag <= 1'b1;
    rst();
    i_m.pulse(3'h4);
    repeat (2) @(negedge clock);
    chk("init_disc", 0, discovery_active);
    @(posedge clock);
    init_finished_flag <= 1'b0;
    // global address write on an unprogrammed device, then switch close
    a = 4'($urandom_range(1, 15));
    i_m.send('{GLOBAL_ADDR, CMD_WR_ADDR, {4'h0, a}}, acc);
    chk("glob", 1, acc);
    @(negedge clock);
    chk("glob_addr", {1'b1, a}, {addr_valid, phys_addr});
    i_m.send('{a, 4'($urandom), 8'($urandom)}, acc);
    chk("own2", 1, acc);
    i_m.send('{GLOBAL_ADDR, CMD_WR_ADDR, 8'h05}, acc);
    chk("glob2", 0, acc);
    chk("sw_off", 0, bus_switch_on);
    i_m.pulse(3'h1);
    repeat (2) @(negedge clock);
    chk("sw_on", 1, bus_switch_on);
    $display("test global write done");
    // programmed address: discovery and global write are ignored
    @(posedge clock);
    otp <= 4'($urandom_range(1, 15));
    rst();
    i_m.send('{GLOBAL_ADDR, CMD_WR_ADDR, 8'h05}, acc);
    chk("otp_glob", 0, acc);
    i_m.pulse(3'h4);
    repeat (2) @(negedge clock);
    chk("otp_disc", 0, discovery_active);
    i_m.send('{otp, 4'($urandom), 8'($urandom)}, acc);
    chk("otp_own", 1, acc);
    $display("test programmed done");
    // response drive, undervoltage cut and recovery
    resp_req <= resp_drive_t'(2'($urandom_range(1, 3)));
    repeat (3) @(negedge clock);
    chk("drive", resp_req, resp_drive);
    @(posedge clock);
    {bus_uv, buffer_supply_uv} <= 2'h1 << $urandom_range(0, 1);
    repeat (5) @(negedge clock);
    chk("uv_cut", 0, resp_drive);
    @(posedge clock);
    {bus_uv, buffer_supply_uv} <= 2'h0;
    repeat (RCV_CYC - 100) @(negedge clock);
    chk("rcv_hold", 0, resp_drive);
    i_m.send('{otp, 4'($urandom), 8'($urandom)}, acc);
    chk("rcv_ref", 0, acc);
    repeat (200) @(negedge clock);
    chk("rcv_back", resp_req, resp_drive);
    // overvoltage halts the block as well
    @(posedge clock);
    overvoltage <= 1'b1;
    repeat (4) @(negedge clock);
    chk("ov_cut", 0, resp_drive);
    i_m.send('{otp, 4'($urandom), 8'($urandom)}, acc);
    chk("ov_ref", 0, acc);
    overvoltage <= 1'b0;
    $display("test undervoltage done");
    results();
  end
endmodule // dsi3_slave_phy_address_assign_bench
